// ---- design/link_ctrl_pkg.sv ----
// Package for the link control set/clear register bank.
// Assumes a 32-bit classic Wishbone slave on one clock.
`default_nettype none
package link_ctrl_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] LINK_CTRL_SET_OFS = 8'hE0;
  localparam logic [7:0] LINK_CTRL_CLR_OFS = 8'hE4;
  // Field positions
  localparam int ROLLOVER_SRC_BIT = 22;
  localparam int CYCLE_MASTER_BIT = 21;
  localparam int TIMER_RUN_BIT    = 20;
  localparam int PHY_ACCEPT_BIT   = 10;
  localparam int SELFID_ACCEPT_BIT = 9;
  localparam int TAG1_LOCK_BIT    = 6;
  // Writable bits mask and reset value
  localparam logic [31:0] LINK_CTRL_MASK  = 32'h0070_0640;
  localparam logic [31:0] LINK_CTRL_RESET = 32'h0000_0000;
  // Cycle timer: 3072 ticks of the 24.576 MHz clock per 125 us cycle
  localparam logic [11:0] CYCLE_OFFSET_LAST = 12'hBFF;
  localparam int          CYCLE_OFFSET_W    = 12;
  localparam int          CYCLE_COUNT_W     = 13;

  typedef struct packed {
    logic        rollover_source_select;
    logic        cycle_master_enable;
    logic        cycle_timer_run;
    logic        phy_packet_accept;
    logic        self_identification_accept;
    logic        tag_one_filter_lock;
  } link_ctrl_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage
`default_nettype wire

// ---- design/cycle_timer_core.sv ----
// Cycle timer offset and cycle counter with selectable rollover source.
// Assumes tick_i is a one-cycle strobe of the 24.576 MHz timebase on clk_i.
`default_nettype none
module cycle_timer_core
  import link_ctrl_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // Control
  input  wire logic                      run_i,
  input  wire logic                      ext_src_i,
  input  wire logic                      ext_event_i,
  input  wire logic                      tick_i,
  // Status
  output logic [CYCLE_OFFSET_W-1:0]      offset_o,
  output logic [CYCLE_COUNT_W-1:0]       count_o,
  output logic                           rollover_o
);
  logic [CYCLE_OFFSET_W-1:0] offset_reg;
  logic [CYCLE_COUNT_W-1:0]  count_reg;
  logic                      roll_reg;
  wire int_roll  = run_i && tick_i && !ext_src_i && (offset_reg == CYCLE_OFFSET_LAST);
  wire ext_roll  = run_i && ext_src_i && ext_event_i;
  wire roll_now  = int_roll || ext_roll;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_reg <= '0;
      count_reg  <= '0;
      roll_reg   <= 1'b0;
    end else if (ce_i) begin
      roll_reg <= roll_now;
      if (roll_now) begin
        offset_reg <= '0;
        count_reg  <= count_reg + 1'b1;
      end else if (run_i && tick_i) begin
        offset_reg <= offset_reg + 1'b1;
      end
    end
  end

  assign offset_o   = offset_reg;
  assign count_o    = count_reg;
  assign rollover_o = roll_reg;
endmodule // cycle_timer_core
`default_nettype wire

// ---- design/link_control_set_clear.sv ----
// Link control register with set and clear views on classic Wishbone,
// plus the cycle timer and receive gating that the flags steer.
// Assumes cycle_overrun_flag_i comes from the interrupt event logic on clk_i
// and external_cycle_input_i, global_reset_pin_i are asynchronous pins.
`default_nettype none
module link_control_set_clear
  import link_ctrl_pkg::*;
#(
  parameter int NUM_ISO_CTX = 4
) (
  // Clock, reset, clock enable
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // Wishbone slave
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic [31:0]                 dat_o,
  output logic                        ack_o,
  // Pins and neighbouring logic
  input  wire logic                   global_reset_pin_i,
  input  wire logic                   external_cycle_input_i,
  input  wire logic                   tick_24m_i,
  input  wire logic                   cycle_overrun_flag_i,
  input  wire logic                   cycle_start_rx_i,
  input  wire logic                   phy_pkt_rx_i,
  input  wire logic                   selfid_pkt_rx_i,
  input  wire logic                   ar_req_ctx_enabled_i,
  input  wire logic [NUM_ISO_CTX-1:0] tag_one_sync_filter_sw_i,
  // Outputs to the link core
  output logic                        cycle_start_tx_o,
  output logic                        cycle_sync_o,
  output logic                        phy_pkt_to_ar_o,
  output logic                        selfid_pkt_accept_o,
  output logic [NUM_ISO_CTX-1:0]      tag_one_sync_filter_o,
  output logic [CYCLE_OFFSET_W-1:0]   cycle_offset_o,
  output logic [CYCLE_COUNT_W-1:0]    cycle_count_o
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] global_reset_pin_sync_reg;
  logic [2:0] cyin_sync_reg;
  logic       global_reset_pin_state_reg;
  logic       cyin_state_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_reset_pin_sync_reg  <= 3'h0;
      cyin_sync_reg  <= 3'h0;
      global_reset_pin_state_reg <= 1'b0;
      cyin_state_reg <= 1'b0;
    end else if (ce_i) begin
      global_reset_pin_sync_reg <= {global_reset_pin_sync_reg[1:0], global_reset_pin_i};
      cyin_sync_reg <= {cyin_sync_reg[1:0], external_cycle_input_i};
      // A change counts only once stages two and three agree
      if (global_reset_pin_sync_reg[1] == global_reset_pin_sync_reg[2]) begin
        global_reset_pin_state_reg <= global_reset_pin_sync_reg[2];
      end
      if (cyin_sync_reg[1] == cyin_sync_reg[2]) begin
        cyin_state_reg <= cyin_sync_reg[2];
      end
    end
  end

  wire cyin_agree = (cyin_sync_reg[1] == cyin_sync_reg[2]);
  wire cyin_rise  = cyin_agree && cyin_sync_reg[2] && !cyin_state_reg;
  wire global_reset_pin_agree = (global_reset_pin_sync_reg[1] == global_reset_pin_sync_reg[2]);
  wire global_reset_pin_now   = global_reset_pin_agree ? global_reset_pin_sync_reg[2] : global_reset_pin_state_reg;

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  logic         ack_reg;
  logic [31:0]  dat_reg;
  link_ctrl_t   ctrl_reg;
  link_ctrl_t   ctrl_next;
  logic         overrun_d_reg;

  wire          req_new   = cyc_i && stb_i && !ack_reg;
  wire          hit_set   = (adr_i == LINK_CTRL_SET_OFS);
  wire          hit_clr   = (adr_i == LINK_CTRL_CLR_OFS);
  wire          hit_any   = hit_set || hit_clr;
  wire [31:0]   lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0]   wr_bits   = dat_i & lane_mask & LINK_CTRL_MASK;
  wire [31:0]   set_bits  = (req_new && we_i && hit_set) ? wr_bits : 32'h0000_0000;
  wire [31:0]   clr_bits  = (req_new && we_i && hit_clr) ? wr_bits : 32'h0000_0000;
  wire          overrun_rise = cycle_overrun_flag_i && !overrun_d_reg;

  wire [31:0]   ctrl_word = {9'h000, ctrl_reg.rollover_source_select, ctrl_reg.cycle_master_enable,
                             ctrl_reg.cycle_timer_run, 9'h000, ctrl_reg.phy_packet_accept,
                             ctrl_reg.self_identification_accept, 2'h0, ctrl_reg.tag_one_filter_lock,
                             6'h00};

  // ****************************************************************
  // Control register update
  // ****************************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.rollover_source_select =
      (ctrl_reg.rollover_source_select | set_bits[ROLLOVER_SRC_BIT]) & ~clr_bits[ROLLOVER_SRC_BIT];
    ctrl_next.cycle_timer_run =
      (ctrl_reg.cycle_timer_run | set_bits[TIMER_RUN_BIT]) & ~clr_bits[TIMER_RUN_BIT];
    ctrl_next.phy_packet_accept =
      (ctrl_reg.phy_packet_accept | set_bits[PHY_ACCEPT_BIT]) & ~clr_bits[PHY_ACCEPT_BIT];
    ctrl_next.self_identification_accept =
      (ctrl_reg.self_identification_accept | set_bits[SELFID_ACCEPT_BIT]) & ~clr_bits[SELFID_ACCEPT_BIT];
    ctrl_next.cycle_master_enable =
      (ctrl_reg.cycle_master_enable | (set_bits[CYCLE_MASTER_BIT] & ~cycle_overrun_flag_i))
      & ~clr_bits[CYCLE_MASTER_BIT];
    if (overrun_rise) begin
      ctrl_next.cycle_master_enable = 1'b0;
    end
    // lock is set only; clear view has no effect
    ctrl_next.tag_one_filter_lock = ctrl_reg.tag_one_filter_lock | set_bits[TAG1_LOCK_BIT];
    if (global_reset_pin_now) begin
      ctrl_next.tag_one_filter_lock = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg      <= '0;
      ack_reg       <= 1'b0;
      dat_reg       <= LINK_CTRL_RESET;
      overrun_d_reg <= 1'b0;
    end else if (ce_i) begin
      ctrl_reg      <= ctrl_next;
      overrun_d_reg <= cycle_overrun_flag_i;
      ack_reg       <= req_new;
      // Unmapped reads return zero; writes there are dropped
      dat_reg       <= (req_new && !we_i && hit_any) ? ctrl_word : 32'h0000_0000;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // ****************************************************************
  // Cycle timer
  // ****************************************************************
  logic [CYCLE_OFFSET_W-1:0] offset_w;
  logic [CYCLE_COUNT_W-1:0]  count_w;
  logic                      roll_w;

  // external source; 3072 tick rollover; run gate
  cycle_timer_core u_timer (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .run_i       (ctrl_reg.cycle_timer_run),
    .ext_src_i   (ctrl_reg.rollover_source_select),
    .ext_event_i (cyin_rise),
    .tick_i      (tick_24m_i),
    .offset_o    (offset_w),
    .count_o     (count_w),
    .rollover_o  (roll_w)
  );

  // ****************************************************************
  // Link core outputs
  // ****************************************************************
  logic                   cs_tx_reg;
  logic                   sync_reg;
  logic                   phy_reg;
  logic                   sid_reg;
  logic [NUM_ISO_CTX-1:0] tag_reg;
  logic [NUM_ISO_CTX-1:0] tag_next;

  // forced to one; software value passes
  genvar g;
  generate
    for (g = 0; g < NUM_ISO_CTX; g++) begin : g_tag
      assign tag_next[g] = ctrl_reg.tag_one_filter_lock | tag_one_sync_filter_sw_i[g];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_tx_reg <= 1'b0;
      sync_reg  <= 1'b0;
      phy_reg   <= 1'b0;
      sid_reg   <= 1'b0;
      tag_reg   <= '0;
    end else if (ce_i) begin
      // cycle start on rollover as master
      cs_tx_reg <= roll_w && ctrl_reg.cycle_master_enable;
      sync_reg  <= cycle_start_rx_i && !ctrl_reg.cycle_master_enable;
      // PHY packets into AR request context
      phy_reg   <= phy_pkt_rx_i && ctrl_reg.phy_packet_accept && ar_req_ctx_enabled_i;
      // self-ID gated by its own bit only; is software's duty
      sid_reg   <= selfid_pkt_rx_i && ctrl_reg.self_identification_accept;
      tag_reg   <= tag_next;
    end
  end

  assign cycle_start_tx_o      = cs_tx_reg;
  assign cycle_sync_o          = sync_reg;
  assign phy_pkt_to_ar_o       = phy_reg;
  assign selfid_pkt_accept_o   = sid_reg;
  assign tag_one_sync_filter_o = tag_reg;
  assign cycle_offset_o        = offset_w;
  assign cycle_count_o         = count_w;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> (dat_o & ~LINK_CTRL_MASK) == 32'h0000_0000) else $error("reserved bit read nonzero");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && ce_i |=> !ack_o) else $error("ack held over two cycles");
  a_set_works: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_new && we_i && hit_set && wr_bits[PHY_ACCEPT_BIT] |=> ctrl_reg.phy_packet_accept)
    else $error("set view did not set bit");
  a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_new && we_i && hit_clr && wr_bits[TIMER_RUN_BIT] |=> !ctrl_reg.cycle_timer_run)
    else $error("clear view did not clear bit");
  a_master_auto_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && overrun_rise |=> !ctrl_reg.cycle_master_enable) else $error("master survived overrun");
  a_master_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cycle_overrun_flag_i && !ctrl_reg.cycle_master_enable |=> !ctrl_reg.cycle_master_enable)
    else $error("master set during overrun");
  a_offset_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !ctrl_reg.cycle_timer_run && !roll_w |=> $stable(cycle_offset_o))
    else $error("offset moved while stopped");
  a_lock_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctrl_reg.tag_one_filter_lock && !global_reset_pin_now |=> ctrl_reg.tag_one_filter_lock)
    else $error("lock cleared without global reset");
  a_tag_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctrl_reg.tag_one_filter_lock |=> &tag_one_sync_filter_o) else $error("tag filter not forced");
  a_cycle_start: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && roll_w && ctrl_reg.cycle_master_enable |=> cycle_start_tx_o) else $error("no cycle start");
  a_phy_gate_closed: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && phy_pkt_rx_i && !(ctrl_reg.phy_packet_accept && ar_req_ctx_enabled_i) |=> !phy_pkt_to_ar_o)
    else $error("PHY packet passed a closed gate");
  a_selfid_accept: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && selfid_pkt_rx_i && ctrl_reg.self_identification_accept |=> selfid_pkt_accept_o)
    else $error("self-ID packet not accepted");
  a_sync_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cycle_start_rx_i && !ctrl_reg.cycle_master_enable |=> cycle_sync_o)
    else $error("received cycle start not followed");
  a_lock_global_reset_pin_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && global_reset_pin_now |=> !ctrl_reg.tag_one_filter_lock)
    else $error("lock survived global reset");
endmodule // link_control_set_clear
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the link control set/clear register bank.
// Assumes a registered one-cycle Wishbone ack and registered one-cycle side pulses.
`default_nettype none
module tb
  import link_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SET = LINK_CTRL_SET_OFS;
  localparam logic [7:0] CLR = LINK_CTRL_CLR_OFS;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0, sw_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        gpin_i = 1'b0, ext_i = 1'b0, tick_i = 1'b0, ovr_i = 1'b0, ce_i = 1'b1;
  logic        csrx_i = 1'b0, phyrx_i = 1'b0, sidrx_i = 1'b0, aren_i = 1'b0;
  wire  [31:0] dat_o;
  wire         ack_o, cs_tx_o, sync_o, phy_o, sid_o;
  wire  [3:0]  filt_o;
  wire  [11:0] ofs_o;
  wire  [12:0] cnt_o;
  logic [31:0] model = 32'h0, q;
  int          mismatches = 0, checks_done = 0, cycles = 0, starts = 0, k, i;
  always #50 clk_i = ~clk_i;

  link_control_set_clear #(.NUM_ISO_CTX(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .global_reset_pin_i(gpin_i), .external_cycle_input_i(ext_i), .tick_24m_i(tick_i),
    .cycle_overrun_flag_i(ovr_i), .cycle_start_rx_i(csrx_i), .phy_pkt_rx_i(phyrx_i),
    .selfid_pkt_rx_i(sidrx_i), .ar_req_ctx_enabled_i(aren_i), .tag_one_sync_filter_sw_i(sw_i),
    .cycle_start_tx_o(cs_tx_o), .cycle_sync_o(sync_o), .phy_pkt_to_ar_o(phy_o),
    .selfid_pkt_accept_o(sid_o), .tag_one_sync_filter_o(filt_o), .cycle_offset_o(ofs_o),
    .cycle_count_o(cnt_o));

  // ************************************************
  // Checking and expectation helpers
  // ************************************************
  task automatic stop_test();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Clear view never touches the lock; set of master refused under overrun
  function automatic logic [31:0] apply_wr(logic [31:0] m, logic [7:0] a, logic [31:0] d,
                                           logic [3:0] s, logic ovr);
    logic [31:0] e;
    e = d & LINK_CTRL_MASK & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    if (a == CLR) return m & ~(e & ~(32'h0000_0001 << TAG1_LOCK_BIT));
    if (a != SET) return m;
    if (ovr) e[CYCLE_MASTER_BIT] = 1'b0;
    return m | e;
  endfunction

  // ************************************************
  // Wishbone master
  // ************************************************
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
    // Hold until ack is sampled high; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    wb(a, 1'b1, s, d, r);
    model = apply_wr(model, a, d, s, ovr_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(a, 1'b0, 4'hF, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic rx_pulse();
    @(posedge clk_i);
    aren_i <= 1'($urandom_range(1, 0)); csrx_i <= 1'b1; phyrx_i <= 1'b1; sidrx_i <= 1'b1;
    @(posedge clk_i);
    csrx_i <= 1'b0; phyrx_i <= 1'b0; sidrx_i <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, phy_o}, {31'h0, model[PHY_ACCEPT_BIT] & aren_i});
    chk({31'h0, sid_o}, {31'h0, model[SELFID_ACCEPT_BIT]});
    chk({31'h0, sync_o}, {31'h0, ~model[CYCLE_MASTER_BIT]});
  endtask

  task automatic filt_chk();
    @(posedge clk_i);
    sw_i <= 4'($urandom);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({28'h0, filt_o}, {28'h0, sw_i | {4{model[TAG1_LOCK_BIT]}}});
  endtask

  task automatic wait_cnt(output int n);
    logic [12:0] c0;
    c0 = cnt_o;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (cs_tx_o === 1'b1) starts++;
    end while (cnt_o === c0 && n < 4000);
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    void'($urandom(32'h5d5dfe2f));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SET, 32'h0);
    rd(CLR, 32'h0);
    for (i = 0; i < 40; i++) begin
      wr(($urandom_range(1, 0) != 0) ? SET : CLR, $urandom, 4'($urandom));
      rd(($urandom_range(1, 0) != 0) ? SET : CLR, model);
    end
    wr(SET, 32'hFFFF_FFFF, 4'hF);
    rd(CLR, model);
    wr(CLR, 32'hFFFF_FFFF, 4'hF);
    rd(SET, model);
    wr(8'hE8, $urandom, 4'hF);
    rd(8'hE8, 32'h0);
    rd(SET, model);
    for (i = 0; i < 8; i++) begin
      wr(CLR, 32'h0070_0600, 4'hF);
      wr(SET, {10'h0, i[2], 10'h0, i[1], i[0], 9'h0}, 4'hF);
      rx_pulse();
      filt_chk();
    end
    // Overrun handling of the master bit
    wr(SET, 32'h0020_0000, 4'hF);
    rd(SET, model);
    @(posedge clk_i) ovr_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    model[CYCLE_MASTER_BIT] = 1'b0;
    rd(SET, model);
    wr(SET, 32'h0020_0000, 4'hF);
    rd(CLR, model);
    @(posedge clk_i) ovr_i <= 1'b0;
    wr(SET, 32'h0020_0000, 4'hF);
    rd(SET, model);
    // Global reset pin drops the lock
    @(posedge clk_i) gpin_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    gpin_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    model[TAG1_LOCK_BIT] = 1'b0;
    rd(SET, model);
    filt_chk();
    // Cycle timer internal then external rollover
    wr(CLR, 32'h0070_0600, 4'hF);
    wr(SET, 32'h0030_0000, 4'hF);
    @(posedge clk_i) tick_i <= 1'b1;
    wait_cnt(k);
    starts = 0;
    wait_cnt(k);
    chk(32'(k), 32'd3072);
    chk(32'(starts), 32'd1);
    wr(SET, 32'h0040_0000, 4'hF);
    q = {19'h0, cnt_o};
    @(posedge clk_i) ext_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ext_i <= 1'b0;
    repeat (10) @(negedge clk_i);
    chk({19'h0, cnt_o}, q + 32'h1);
    // Clock enable low freezes the running offset
    @(posedge clk_i) ce_i <= 1'b0;
    @(negedge clk_i);
    q = {20'h0, ofs_o};
    repeat (20) @(negedge clk_i);
    chk({20'h0, ofs_o}, q);
    @(posedge clk_i) ce_i <= 1'b1;
    wr(CLR, 32'h0010_0000, 4'hF);
    repeat (3) @(negedge clk_i);
    q = {20'h0, ofs_o};
    repeat (50) @(negedge clk_i);
    chk({20'h0, ofs_o}, q);
    stop_test();
  end
endmodule // tb
`default_nettype wire
